// >>> common/pao_pkg.sv
// Shared constants, types and encodings for the process, alarm and
// output selection channel.
// Assumes a single 20 MHz clock domain.
package pao_pkg;

	// Data widths
	localparam int DATA_W    = 24;
	localparam int MULT_W    = 16;
	localparam int MULT_FRAC = 8;
	localparam int LEVEL_W   = 16;
	localparam int CHAR_W    = 8;
	localparam int TAG_LEN   = 16;
	localparam int TAG_AW    = 4;

	// Output current limit, in microamps
	localparam int LEVEL_MAX_MA = 24;
	localparam logic [LEVEL_W-1:0] LEVEL_MAX_UA = LEVEL_W'(LEVEL_MAX_MA * 1000);

	// Largest hysteresis, in measurement counts (50 mV as microvolts)
	localparam int HYST_MAX_MV = 50;
	localparam int HYST_MAX    = HYST_MAX_MV * 1000;

	// Processing tick timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_MS       = 100;
	localparam int TICK_CYC      = TICK_MS * 1000000 / CLK_PERIOD_NS;

	// Alarm delays, in ticks
	localparam int DELAY_MAX_S     = 1000;
	localparam int DELAY_MAX_STEPS = DELAY_MAX_S * 1000 / TICK_MS;
	localparam int DELAY_W         = 14;

	// Fault vector bit positions
	localparam int FLT_BREAK    = 0;
	localparam int FLT_INTERNAL = 1;
	localparam int FLT_RANGE    = 2;
	localparam int FLT_SAT      = 3;
	localparam int FLT_TEMP     = 4;
	localparam int FLT_N        = 5;

	// Values after reset
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 16'h0000;
	localparam logic               ALARM_RST = 1'b0;

	// Quantity feeding the output or the alarm
	typedef enum logic [2:0] {
		FN_IN1, FN_IN2, FN_SUM, FN_DIFF, FN_MIN, FN_MAX
	} pao_func_t;

	// Alarm types
	typedef enum logic [2:0] {
		AL_NONE, AL_LOW, AL_LOW_ARMED_AFTER_RISE, AL_HIGH,
		AL_HIGH_ARMED_AFTER_FALL, AL_WINDOW, AL_FAULT_REPEAT
	} pao_alarm_t;

	// Alarm behaviour while a selected fault is present
	typedef enum logic [1:0] {
		FP_IGNORE, FP_HOLD, FP_FORCE_ON, FP_FORCE_OFF
	} pao_policy_t;

endpackage

// >>> rtl/pao_scale.sv
// Offset and multiplier stage for one input measurement.
// Assumes the multiplier is signed fixed point with MULT_FRAC bits.
`timescale 1ns/10ps
`default_nettype none
module pao_scale #(
	parameter int DW = pao_pkg::DATA_W
) (
	// Clock, reset, enable
	input  wire logic                             mclk,
	input  wire logic                             reset,
	input  wire logic                             ce,
	// Measurement and settings
	input  wire logic signed [DW-1:0]             raw,
	input  wire logic signed [DW-1:0]             offset,
	input  wire logic signed [pao_pkg::MULT_W-1:0] mult,
	// Scaled result
	output logic signed [DW-1:0]                  scaled
);
	import pao_pkg::*;

	localparam int PW = DW + 1 + MULT_W;
	localparam logic signed [PW-1:0] TOP = PW'(2**(DW-1) - 1);
	localparam logic signed [PW-1:0] BOT = -PW'(2**(DW-1));

	logic signed [DW:0]   sum;
	logic signed [PW-1:0] prod;
	logic signed [PW-1:0] shifted;

	// Offset first, then multiply, then saturate
	assign sum     = (DW+1)'(raw) + offset;
	assign prod    = PW'(sum) * PW'(mult);
	assign shifted = prod >>> MULT_FRAC;

	// Registered scaled value
	always_ff @(posedge mclk) begin
		if (reset) begin
			scaled <= '0;
		end else if (ce) begin
			if (shifted > TOP)
				scaled <= TOP[DW-1:0];
			else if (shifted < BOT)
				scaled <= BOT[DW-1:0];
			else
				scaled <= shifted[DW-1:0];
		end
	end

endmodule
`default_nettype wire

// >>> rtl/pao_tag_mem.sv
// Small memory holding the channel tag characters.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/10ps
`default_nettype none
module pao_tag_mem #(
	parameter int DEPTH = pao_pkg::TAG_LEN,
	parameter int AW    = pao_pkg::TAG_AW,
	parameter int W     = pao_pkg::CHAR_W
) (
	// Clock, reset, enable
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic          ce,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [W-1:0]  wrData,
	// Read port
	input  wire logic [AW-1:0] rdAddr,
	output logic [W-1:0]       rdData
);
	import pao_pkg::*;

	if (DEPTH > 2**AW || DEPTH < 1) begin : g_chk
		$error("tag depth exceeds address range");
	end

	logic [W-1:0] mem [DEPTH];

	// Character storage
	always_ff @(posedge mclk) begin
		if (ce && we && 32'(wrAddr) < DEPTH)
			mem[wrAddr] <= wrData;
	end

	// Registered read, zero beyond the tag length
	always_ff @(posedge mclk) begin
		if (reset)
			rdData <= '0;
		else if (ce)
			rdData <= (32'(rdAddr) < DEPTH) ? mem[rdAddr] : '0;
	end

endmodule
`default_nettype wire

// >>> rtl/pao_channel.sv
// One converter channel: scaling, output selection and alarm.
// Assumes async fault pins, settings static between ticks.
// Contract
// - Offset then multiply each input first.
// - Hold a sixteen character tag.
// - Output: either input, sum, difference, min, max.
// - Map function onto levels; under/over levels.
// - Enabled fault forces the fault level.
// - Each fault cause individually enabled.
// - Saturation when outside under/over levels.
// - Flag input outside measuring range.
// - Alarm source independent of output.
// - Low type alarms below low setpoint.
// - Armed-after-rise low waits for first rise.
// - High type alarms above high setpoint.
// - Armed-after-fall high waits for first fall.
// - Window alarms below low or above high.
// - Fault repeater follows selected faults.
// - Energized or de-energized when inactive.
// - Low clears at setpoint plus hysteresis.
// - High clears at setpoint minus hysteresis.
// - On delay in 100 ms steps.
// - Off delay in 100 ms steps.
// - Fault policy: ignore, hold, force on/off.
// - Only selected faults trigger the policy.
`timescale 1ns/10ps
`default_nettype none
module pao_channel #(
	parameter int DW          = pao_pkg::DATA_W,
	parameter int TICK_CYCLES = pao_pkg::TICK_CYC
) (
	// Clock, reset, enable
	input  wire logic                              mclk,
	input  wire logic                              reset,
	input  wire logic                              ce,
	// Raw measurements
	input  wire logic signed [DW-1:0]              in1Raw,
	input  wire logic signed [DW-1:0]              in2Raw,
	// Input scaling
	input  wire logic signed [DW-1:0]              offset1,
	input  wire logic signed [DW-1:0]              offset2,
	input  wire logic signed [pao_pkg::MULT_W-1:0] mult1,
	input  wire logic signed [pao_pkg::MULT_W-1:0] mult2,
	// Input measuring range
	input  wire logic signed [DW-1:0]              inRangeLo,
	input  wire logic signed [DW-1:0]              inRangeHi,
	// Output settings
	input  wire pao_pkg::pao_func_t                outFunc,
	input  wire logic signed [DW-1:0]              lowScale,
	input  wire logic signed [DW-1:0]              upScale,
	input  wire logic [pao_pkg::LEVEL_W-1:0]       lowLevel,
	input  wire logic [pao_pkg::LEVEL_W-1:0]       highLevel,
	input  wire logic [pao_pkg::LEVEL_W-1:0]       underLevel,
	input  wire logic [pao_pkg::LEVEL_W-1:0]       overLevel,
	input  wire logic [pao_pkg::LEVEL_W-1:0]       faultLevel,
	input  wire logic [pao_pkg::FLT_N-1:0]         outFaultMask,
	// Asynchronous fault pins
	input  wire logic                              sensorBreakPin,
	input  wire logic                              internalFaultPin,
	input  wire logic                              tempFaultPin,
	// Alarm settings
	input  wire pao_pkg::pao_alarm_t               alarmType,
	input  wire pao_pkg::pao_func_t                alarmSrc,
	input  wire logic                              energizedWhenInactive,
	input  wire logic signed [DW-1:0]              lowSet,
	input  wire logic signed [DW-1:0]              highSet,
	input  wire logic [DW-2:0]                     lowHyst,
	input  wire logic [DW-2:0]                     highHyst,
	input  wire logic [pao_pkg::DELAY_W-1:0]       onDelay,
	input  wire logic [pao_pkg::DELAY_W-1:0]       offDelay,
	input  wire pao_pkg::pao_policy_t              faultPolicy,
	input  wire logic [pao_pkg::FLT_N-1:0]         alarmFaultMask,
	// Tag access
	input  wire logic                              tagWe,
	input  wire logic [pao_pkg::TAG_AW-1:0]        tagWrAddr,
	input  wire logic [pao_pkg::CHAR_W-1:0]        tagWrData,
	input  wire logic [pao_pkg::TAG_AW-1:0]        tagRdAddr,
	output logic [pao_pkg::CHAR_W-1:0]             tagRdData,
	// Results
	output logic [pao_pkg::LEVEL_W-1:0]            outLevel,
	output logic                                   underrange,
	output logic                                   overrange,
	output logic                                   outSaturated,
	output logic                                   rangeFault,
	output logic                                   outFaultActive,
	output logic                                   alarmActive,
	output logic                                   alarmPinDrive,
	output logic                                   tick
);
	import pao_pkg::*;

	if (DW < 8 || DW > 32) begin : g_chk_dw
		$error("data width out of range");
	end
	if (TICK_CYCLES < 2) begin : g_chk_tick
		$error("tick period too short");
	end

	localparam int TCW   = $clog2(TICK_CYCLES);
	localparam int NUM_W = DW + LEVEL_W + 3;
	localparam int BCW   = $clog2(NUM_W + 1);
	localparam int CW    = LEVEL_W + 3;
	localparam int AW2   = DW + 2;
	localparam logic [NUM_W-1:0] QCAP = NUM_W'(2**(LEVEL_W+1) - 1);
	localparam logic [AW2-1:0] HCAP = AW2'(HYST_MAX);

	typedef enum logic [1:0] {DV_IDLE, DV_RUN, DV_DONE} pao_div_t;

	// Select one of the input combinations
	function automatic logic signed [DW:0] selectFunc(
		pao_func_t f, logic signed [DW-1:0] a, logic signed [DW-1:0] b);
		logic signed [DW:0] ea;
		logic signed [DW:0] eb;
		ea = {a[DW-1], a};
		eb = {b[DW-1], b};
		unique case (f)
			FN_IN1:  return ea;
			FN_IN2:  return eb;
			FN_SUM:  return ea + eb;
			FN_DIFF: return ea - eb;
			FN_MIN:  return (ea < eb) ? ea : eb;
			FN_MAX:  return (ea > eb) ? ea : eb;
			default: return ea;
		endcase
	endfunction

	// Limit a level to the 0..24 mA span
	function automatic logic [LEVEL_W-1:0] capLevel(logic [LEVEL_W-1:0] x);
		return (x > LEVEL_MAX_UA) ? LEVEL_MAX_UA : x;
	endfunction

	// Limit hysteresis to its largest allowed value
	function automatic logic signed [AW2-1:0] capHyst(logic [DW-2:0] h);
		logic [AW2-1:0] e;
		e = AW2'(h);
		return (e > HCAP) ? HCAP : e;
	endfunction

	// Periodic processing tick
	logic [TCW-1:0] tickCnt_q;
	always_ff @(posedge mclk) begin
		if (reset) begin
			tickCnt_q <= '0;
			tick <= 1'b0;
		end else if (ce) begin
			tick <= (tickCnt_q == TCW'(TICK_CYCLES - 1));
			if (tickCnt_q == TCW'(TICK_CYCLES - 1))
				tickCnt_q <= '0;
			else
				tickCnt_q <= tickCnt_q + 1'b1;
		end
	end

	// Fault pin synchronisers, change taken when stages two and three agree
	logic [2:0] pinIn;
	logic [2:0] pinS1_q;
	logic [2:0] pinS2_q;
	logic [2:0] pinS3_q;
	logic [2:0] pinOk_q;
	assign pinIn = {tempFaultPin, internalFaultPin, sensorBreakPin};
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge mclk) begin
			if (reset) begin
				pinS1_q[i] <= 1'b0;
				pinS2_q[i] <= 1'b0;
				pinS3_q[i] <= 1'b0;
				pinOk_q[i] <= 1'b0;
			end else if (ce) begin
				pinS1_q[i] <= pinIn[i];
				pinS2_q[i] <= pinS1_q[i];
				pinS3_q[i] <= pinS2_q[i];
				if (pinS2_q[i] == pinS3_q[i])
					pinOk_q[i] <= pinS3_q[i];
			end
		end
	end

	// Scaled inputs
	logic signed [DW-1:0] s1;
	logic signed [DW-1:0] s2;
	pao_scale #(.DW(DW)) u_scale1 (
		.mclk   (mclk),
		.reset  (reset),
		.ce     (ce),
		.raw    (in1Raw),
		.offset (offset1),
		.mult   (mult1),
		.scaled (s1)
	);
	pao_scale #(.DW(DW)) u_scale2 (
		.mclk   (mclk),
		.reset  (reset),
		.ce     (ce),
		.raw    (in2Raw),
		.offset (offset2),
		.mult   (mult2),
		.scaled (s2)
	);

	// Channel tag storage
	pao_tag_mem u_tag (
		.mclk   (mclk),
		.reset  (reset),
		.ce     (ce),
		.we     (tagWe),
		.wrAddr (tagWrAddr),
		.wrData (tagWrData),
		.rdAddr (tagRdAddr),
		.rdData (tagRdData)
	);

	// Fault vector and its two selections
	logic [FLT_N-1:0] faultVec;
	logic             outFault;
	logic             almFault;
	assign faultVec[FLT_BREAK]    = pinOk_q[0];
	assign faultVec[FLT_INTERNAL] = pinOk_q[1];
	assign faultVec[FLT_TEMP]     = pinOk_q[2];
	assign faultVec[FLT_RANGE]    = rangeFault;
	assign faultVec[FLT_SAT]      = outSaturated;
	assign outFault = |(faultVec & outFaultMask);
	assign almFault = |(faultVec & alarmFaultMask);

	// Input measuring range check
	always_ff @(posedge mclk) begin
		if (reset)
			rangeFault <= 1'b0;
		else if (ce && tick)
			rangeFault <= (s1 < inRangeLo) || (s1 > inRangeHi) ||
				(s2 < inRangeLo) || (s2 > inRangeHi);
	end

	// Linear mapping by a serial divider, started on each tick
	pao_div_t             dvState_q;
	logic [NUM_W-1:0]     num_q;
	logic [NUM_W-1:0]     quo_q;
	logic [DW:0]          den_q;
	logic [DW:0]          rem_q;
	logic [BCW-1:0]       bit_q;
	logic                 neg_q;
	logic signed [DW:0]   outVal;
	logic signed [AW2-1:0] diff;
	logic signed [LEVEL_W:0] span;
	logic signed [DW:0]   den;
	logic signed [NUM_W-1:0] prod;
	logic [DW+1:0]        remSh;
	assign outVal = selectFunc(outFunc, s1, s2);
	assign diff   = AW2'(outVal) - AW2'(lowScale);
	assign span   = $signed({1'b0, capLevel(highLevel)}) -
		$signed({1'b0, capLevel(lowLevel)});
	assign den    = (DW+1)'(upScale) - (DW+1)'(lowScale);
	assign prod   = NUM_W'(diff) * NUM_W'(span);
	assign remSh  = {rem_q, num_q[NUM_W-1]};

	always_ff @(posedge mclk) begin
		if (reset) begin
			dvState_q <= DV_IDLE;
			num_q <= '0;
			quo_q <= '0;
			den_q <= '0;
			rem_q <= '0;
			bit_q <= '0;
			neg_q <= 1'b0;
		end else if (ce) begin
			unique case (dvState_q)
				DV_IDLE: begin
					if (tick) begin
						neg_q <= prod[NUM_W-1];
						num_q <= prod[NUM_W-1] ? NUM_W'(-prod) : NUM_W'(prod);
						den_q <= (den > 0) ? den : '0;
						rem_q <= '0;
						quo_q <= '0;
						bit_q <= BCW'(NUM_W);
						dvState_q <= DV_RUN;
					end
				end
				DV_RUN: begin
					num_q <= num_q << 1;
					if (den_q != '0 && remSh >= {1'b0, den_q}) begin
						rem_q <= (DW+1)'(remSh - {1'b0, den_q});
						quo_q <= {quo_q[NUM_W-2:0], 1'b1};
					end else begin
						rem_q <= remSh[DW:0];
						quo_q <= {quo_q[NUM_W-2:0], 1'b0};
					end
					bit_q <= bit_q - 1'b1;
					if (bit_q == BCW'(1))
						dvState_q <= DV_DONE;
				end
				DV_DONE: dvState_q <= DV_IDLE;
			endcase
		end
	end

	// Computed output from the quotient
	logic [NUM_W-1:0]    qCap;
	logic signed [CW-1:0] comp;
	logic signed [CW-1:0] underS;
	logic signed [CW-1:0] overS;
	assign qCap   = (quo_q > QCAP) ? QCAP : quo_q;
	assign comp   = neg_q ? CW'(capLevel(lowLevel)) - CW'(qCap) :
		CW'(capLevel(lowLevel)) + CW'(qCap);
	assign underS = CW'(capLevel(underLevel));
	assign overS  = CW'(capLevel(overLevel));

	// Range decision and normal level, once per computation
	logic [LEVEL_W-1:0] baseLevel_q;
	always_ff @(posedge mclk) begin
		if (reset) begin
			baseLevel_q <= LEVEL_RST;
			underrange <= 1'b0;
			overrange <= 1'b0;
			outSaturated <= 1'b0;
		end else if (ce && dvState_q == DV_DONE) begin
			underrange <= comp < underS;
			overrange <= comp > overS;
			outSaturated <= (comp < underS) || (comp > overS);
			if (comp < underS)
				baseLevel_q <= capLevel(underLevel);
			else if (comp > overS)
				baseLevel_q <= capLevel(overLevel);
			else if (comp > CW'(LEVEL_MAX_UA))
				baseLevel_q <= LEVEL_MAX_UA;
			else if (comp < 0)
				baseLevel_q <= '0;
			else
				baseLevel_q <= comp[LEVEL_W-1:0];
		end
	end

	// Fault override of the analog output
	always_ff @(posedge mclk) begin
		if (reset) begin
			outLevel <= LEVEL_RST;
			outFaultActive <= 1'b0;
		end else if (ce) begin
			outFaultActive <= outFault;
			outLevel <= outFault ? capLevel(faultLevel) : baseLevel_q;
		end
	end

	// Alarm comparisons with hysteresis
	logic signed [AW2-1:0] src;
	logic signed [AW2-1:0] lowS;
	logic signed [AW2-1:0] highS;
	logic                  lowCond_q;
	logic                  highCond_q;
	logic                  lowCond_d;
	logic                  highCond_d;
	assign src   = AW2'(selectFunc(alarmSrc, s1, s2));
	assign lowS  = AW2'(lowSet);
	assign highS = AW2'(highSet);

	always_comb begin
		lowCond_d = lowCond_q;
		if (!lowCond_q && src < lowS)
			lowCond_d = 1'b1;
		else if (lowCond_q && src >= lowS + capHyst(lowHyst))
			lowCond_d = 1'b0;
		highCond_d = highCond_q;
		if (!highCond_q && src > highS)
			highCond_d = 1'b1;
		else if (highCond_q && src <= highS - capHyst(highHyst))
			highCond_d = 1'b0;
	end

	// Arming of the locked types
	logic lowAlarmArmedAfterRise_q;
	logic highAlarmArmedAfterFall_q;
	always_ff @(posedge mclk) begin
		if (reset) begin
			lowCond_q <= 1'b0;
			highCond_q <= 1'b0;
			lowAlarmArmedAfterRise_q <= 1'b0;
			highAlarmArmedAfterFall_q <= 1'b0;
		end else if (ce && tick) begin
			lowCond_q <= lowCond_d;
			highCond_q <= highCond_d;
			if (alarmType != AL_LOW_ARMED_AFTER_RISE)
				lowAlarmArmedAfterRise_q <= 1'b0;
			else if (src > lowS)
				lowAlarmArmedAfterRise_q <= 1'b1;
			if (alarmType != AL_HIGH_ARMED_AFTER_FALL)
				highAlarmArmedAfterFall_q <= 1'b0;
			else if (src < highS)
				highAlarmArmedAfterFall_q <= 1'b1;
		end
	end

	// Undelayed alarm condition by type
	logic rawAlarm;
	always_comb begin
		unique case (alarmType)
			AL_NONE: rawAlarm = 1'b0;
			AL_LOW: rawAlarm = lowCond_d;
			AL_LOW_ARMED_AFTER_RISE: rawAlarm = lowAlarmArmedAfterRise_q && lowCond_d;
			AL_HIGH: rawAlarm = highCond_d;
			AL_HIGH_ARMED_AFTER_FALL: rawAlarm = highAlarmArmedAfterFall_q && highCond_d;
			AL_WINDOW: rawAlarm = lowCond_d || highCond_d;
			AL_FAULT_REPEAT: rawAlarm = almFault;
			default: rawAlarm = 1'b0;
		endcase
	end

	// On and off delays counted in ticks
	logic                dlyState_q;
	logic [DELAY_W-1:0]  dlyCnt_q;
	logic [DELAY_W-1:0]  dlyLimit;
	assign dlyLimit = dlyState_q ? offDelay : onDelay;
	always_ff @(posedge mclk) begin
		if (reset) begin
			dlyState_q <= ALARM_RST;
			dlyCnt_q <= '0;
		end else if (ce && tick) begin
			if (rawAlarm == dlyState_q) begin
				dlyCnt_q <= '0;
			end else if (dlyCnt_q >= dlyLimit) begin
				dlyState_q <= rawAlarm;
				dlyCnt_q <= '0;
			end else begin
				dlyCnt_q <= dlyCnt_q + 1'b1;
			end
		end
	end

	// Fault policy and output sense
	logic almFault_q;
	logic heldAlarm_q;
	logic effAlarm;
	always_comb begin
		if (alarmType == AL_FAULT_REPEAT || !almFault)
			effAlarm = dlyState_q;
		else begin
			unique case (faultPolicy)
				FP_IGNORE:    effAlarm = dlyState_q;
				FP_HOLD:      effAlarm = almFault_q ? heldAlarm_q : alarmActive;
				FP_FORCE_ON:  effAlarm = 1'b1;
				FP_FORCE_OFF: effAlarm = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			almFault_q <= 1'b0;
			heldAlarm_q <= ALARM_RST;
			alarmActive <= ALARM_RST;
			alarmPinDrive <= 1'b0;
		end else if (ce) begin
			almFault_q <= almFault;
			if (almFault && !almFault_q)
				heldAlarm_q <= alarmActive;
			alarmActive <= effAlarm;
			alarmPinDrive <= energizedWhenInactive ? !effAlarm : effAlarm;
		end
	end

endmodule
`default_nettype wire

// >>> sim/pao_channel_properties.sv
// Concurrent checks on the channel ports.
// Assumes ce stays high near ticks.
`timescale 1ns/10ps
`default_nettype none
module pao_channel_props #(
	parameter int TICK_CYCLES = 100
) (
	// Clock and control
	input wire logic			mclk,
	input wire logic			reset,
	input wire logic			ce,
	input wire logic			tick,
	// Settings
	input wire pao_pkg::pao_alarm_t		alarmType,
	input wire pao_pkg::pao_policy_t	faultPolicy,
	input wire logic			energizedWhenInactive,
	input wire logic [pao_pkg::LEVEL_W-1:0]	faultLevel,
	input wire logic [pao_pkg::LEVEL_W-1:0]	underLevel,
	input wire logic [pao_pkg::LEVEL_W-1:0]	overLevel,
	// Results
	input wire logic [pao_pkg::LEVEL_W-1:0]	outLevel,
	input wire logic			underrange,
	input wire logic			overrange,
	input wire logic			outSaturated,
	input wire logic			outFaultActive,
	input wire logic			alarmActive,
	input wire logic			alarmPinDrive
);
	import pao_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	logic [31:0]	gapCnt_q;
	logic		seenTick_q;
	// Enabled cycles since the last tick
	always_ff @(posedge mclk) begin
		if (reset) begin
			gapCnt_q <= 32'h0;
			seenTick_q <= 1'b0;
		end else if (ce) begin
			gapCnt_q <= tick ? 32'h1 : gapCnt_q + 32'h1;
			seenTick_q <= seenTick_q | tick;
		end
	end
	a_tick_period: assert property (seenTick_q && ce |-> tick == (gapCnt_q == TICK_CYCLES))
		else $error("tick spacing wrong");
	a_pin_sense: assert property (!$past(reset) && $past(ce) && $stable(energizedWhenInactive)
		|-> alarmPinDrive == (energizedWhenInactive ^ alarmActive)) else $error("pin sense wrong");
	a_fault_level: assert property (outFaultActive && $past(outFaultActive) && $stable(faultLevel)
		|-> outLevel == faultLevel) else $error("fault level wrong");
	a_under_level: assert property (underrange && $past(underrange) && !outFaultActive
		&& !$past(outFaultActive) |-> outLevel == underLevel) else $error("under level wrong");
	a_over_level: assert property (overrange && $past(overrange) && !outFaultActive
		&& !$past(outFaultActive) |-> outLevel == overLevel) else $error("over level wrong");
	a_sat_flag: assert property (outSaturated == (underrange || overrange))
		else $error("saturation wrong");
	a_level_cap: assert property (outLevel <= LEVEL_MAX_UA)
		else $error("output above limit");
	a_none_quiet: assert property (tick && alarmType == AL_NONE && faultPolicy == FP_IGNORE
		&& !alarmActive |-> ##3 !alarmActive) else $error("disabled alarm on");
	a_alarm_tick: assert property ($changed(alarmActive) && faultPolicy == FP_IGNORE
		&& alarmType != AL_FAULT_REPEAT |-> $past(tick, 2))
		else $error("alarm moved off tick");
	// Main scenarios
	c_tick: cover property (tick);
	c_alarm: cover property ($rose(alarmActive));
	c_fault: cover property ($rose(outFaultActive));
endmodule
bind pao_channel pao_channel_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);
`default_nettype wire

// >>> sim/pao_field_model.sv
// Field sensor model: two measurement sources and a break switch.
// Assumes the bench sets wanted values; an open sensor reads full scale.
`timescale 1ns/10ps
`default_nettype none
module pao_field_model (
	// Clock and wanted values
	input wire logic				mclk,
	input wire logic signed [pao_pkg::DATA_W-1:0]	v1,
	input wire logic signed [pao_pkg::DATA_W-1:0]	v2,
	input wire logic				brk,
	// Sensor side
	output logic signed [pao_pkg::DATA_W-1:0]	in1Raw,
	output logic signed [pao_pkg::DATA_W-1:0]	in2Raw,
	output logic					sensorBreakPin
);
	import pao_pkg::*;
	// Burnout drives sensor one to full scale
	always @(posedge mclk) begin
		in1Raw <= brk ? 24'h7fffff : v1;
		in2Raw <= v2;
		sensorBreakPin <= brk;
	end
endmodule
`default_nettype wire

// >>> sim/pao_channel_tb.sv
// Self-checking bench for one channel.
// Assumes the field model feeds the raw inputs.
`timescale 1ns/10ps
`default_nettype none
module pao_channel_tb;
	import pao_pkg::*;
	localparam int TK = 100;
	typedef struct {
		logic [11:0]	a;
		pao_func_t	f;
		logic [15:0]	lv;
		logic [1:0]	uo;
	} pao_row_t;
	logic		mclk, reset, ce, brk, internalFaultPin, tempFaultPin, sensorBreakPin;
	logic		energizedWhenInactive, tagWe, underrange, overrange, outSaturated;
	logic		rangeFault, outFaultActive, alarmActive, alarmPinDrive, tick;
	logic signed [DATA_W-1:0]	in1Raw, in2Raw, v1, v2, offset1, offset2, inRangeLo;
	logic signed [DATA_W-1:0]	inRangeHi, lowScale, upScale, lowSet, highSet;
	logic signed [MULT_W-1:0]	mult1, mult2;
	logic [LEVEL_W-1:0]	lowLevel, highLevel, underLevel, overLevel, faultLevel, outLevel;
	logic [FLT_N-1:0]	outFaultMask, alarmFaultMask;
	logic [DATA_W-2:0]	lowHyst, highHyst;
	logic [DELAY_W-1:0]	onDelay, offDelay;
	logic [TAG_AW-1:0]	tagWrAddr, tagRdAddr;
	logic [CHAR_W-1:0]	tagWrData, tagRdData;
	pao_func_t	outFunc, alarmSrc;
	pao_alarm_t	alarmType;
	pao_policy_t	faultPolicy;
	int		n_fail = 0, check_count = 0, i;
	// Output rows, raw2 fixed at 200: raw1, function, level, under/over
	pao_row_t	rows[8] = '{
		'{12'h12c, FN_IN1, 16'h37a0, 2'b00},
		'{12'h12c, FN_IN2, 16'h1c20, 2'b00},
		'{12'h12c, FN_SUM, 16'h4420, 2'b00},
		'{12'h12c, FN_DIFF, 16'h2b20, 2'b00},
		'{12'h00a, FN_MIN, 16'h1360, 2'b00},
		'{12'h00a, FN_MAX, 16'h1c20, 2'b00},
		'{12'h00a, FN_DIFF, 16'h0ed8, 2'b10},
		'{12'h258, FN_SUM, 16'h5014, 2'b01}};
	pao_policy_t	pol[5] = '{FP_FORCE_OFF, FP_FORCE_OFF, FP_HOLD, FP_FORCE_ON, FP_IGNORE};
	logic [11:0]	pv[5] = '{12'h032, 12'h032, 12'h0c8, 12'h0c8, 12'h0c8};
	logic [4:0]	pe = 5'b01110;
	logic [4:0]	pm = 5'b11101;
	logic [4:0]	fm[3] = '{5'h01, 5'h02, 5'h10};

	pao_field_model u_field (.*);
	pao_channel #(.TICK_CYCLES(TK)) dut (.*);

	// Clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic stop_test();
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [16:0] g, input logic [16:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Wait n ticks, bounded, then settle
	task automatic tk(input int n);
		repeat (n) begin
			for (int j = 0; tick !== 1'b1; j++) begin
				if (j > 2 * TK) begin
					n_fail++;
					stop_test();
				end
				cyc(1);
			end
			cyc(1);
		end
		cyc(5);
	endtask
	task automatic al(input logic [11:0] v, input int n, input logic e);
		v2 = 24'(v);
		tk(n);
		chk(16'(alarmActive), 16'(e));
	endtask
	// Main sequence
	initial begin
		{reset, ce, brk, internalFaultPin, tempFaultPin, tagWe, energizedWhenInactive} = 7'h60;
		{v1, v2, offset2, lowScale, lowSet, highSet} = '0;
		{offset1, inRangeLo, inRangeHi} = {24'h000014, 24'hfffc18, 24'h0007d0};
		{upScale, mult1, mult2} = {24'h0003e8, 16'h0200, 16'h0100};
		{lowLevel, highLevel, underLevel} = {16'h0fa0, 16'h4e20, 16'h0ed8};
		{overLevel, faultLevel, outFaultMask, alarmFaultMask} = {16'h5014, 16'h0e10, 10'h000};
		{lowHyst, highHyst, onDelay, offDelay, tagWrAddr, tagWrData, tagRdAddr} = '0;
		outFunc = FN_IN1;
		alarmSrc = FN_IN2;
		alarmType = AL_NONE;
		faultPolicy = FP_IGNORE;
		cyc(5);
		reset = 1'b0;
		chk(outLevel, 16'h0000);
		chk(16'(alarmActive), 16'h0000);
		for (i = 0; i < TAG_LEN; i++) begin
			{tagWe, tagWrAddr, tagWrData} = {1'b1, 4'(i), 8'h41 + 8'(i)};
			cyc(1);
		end
		tagWe = 1'b0;
		for (i = 0; i < TAG_LEN; i++) begin
			tagRdAddr = 4'(i);
			cyc(2);
			chk(16'(tagRdData), 16'h0041 + 16'(i));
		end
		for (i = 0; i < 8; i++) begin
			{v1, v2} = {24'(rows[i].a), 24'h0000c8};
			outFunc = rows[i].f;
			tk(2);
			cyc(50);
			chk(outLevel, rows[i].lv);
			chk({underrange, overrange}, rows[i].uo);
		end
		// Low, high, window and armed alarm types with on/off delays and hysteresis
		tk(1);
		{lowSet, lowHyst, onDelay, energizedWhenInactive} = {24'h64, 23'h14, 14'h2, 1'b1};
		alarmType = AL_LOW;
		al(12'h032, 2, 1'b0);
		al(12'h032, 1, 1'b1);
		chk(16'(alarmPinDrive), 16'h0000);
		al(12'h06e, 2, 1'b1);
		al(12'h078, 1, 1'b0);
		chk(16'(alarmPinDrive), 16'h0001);
		{highSet, highHyst, onDelay, offDelay, energizedWhenInactive} = {24'h1f4, 23'h32, 28'h1, 1'b0};
		alarmType = AL_HIGH;
		al(12'h258, 1, 1'b1);
		chk(16'(alarmPinDrive), 16'h0001);
		al(12'h1cc, 2, 1'b1);
		al(12'h1c2, 1, 1'b1);
		al(12'h1c2, 1, 1'b0);
		{lowHyst, highHyst, offDelay} = '0;
		alarmType = AL_WINDOW;
		al(12'h258, 1, 1'b1);
		al(12'h12c, 1, 1'b0);
		al(12'h032, 1, 1'b1);
		alarmType = AL_LOW_ARMED_AFTER_RISE;
		al(12'h032, 2, 1'b0);
		al(12'h096, 1, 1'b0);
		al(12'h032, 1, 1'b1);
		alarmType = AL_HIGH_ARMED_AFTER_FALL;
		al(12'h258, 2, 1'b0);
		al(12'h190, 1, 1'b0);
		al(12'h258, 1, 1'b1);
		// Fault policies with the break fault
		alarmType = AL_LOW;
		outFaultMask = 5'h01;
		for (i = 0; i < 5; i++) begin
			al(12'h032, 1, 1'b1);
			faultPolicy = pol[i];
			alarmFaultMask = {4'h0, pm[i]};
			brk = 1'b1;
			al(pv[i], 1, pe[i]);
			chk(outLevel, faultLevel);
			brk = 1'b0;
			tk(1);
		end
		inRangeHi = 24'h000096;
		tk(1);
		chk(16'(rangeFault), 16'h0001);
		inRangeHi = 24'h0007d0;
		tk(1);
		chk(16'(rangeFault), 16'h0000);
		ce = 1'b0;
		cyc(3 * TK);
		chk(16'(tick), 16'h0000);
		ce = 1'b1;
		// Each fault pin alone, selected then deselected
		alarmType = AL_FAULT_REPEAT;
		for (i = 0; i < 3; i++) begin
			{tempFaultPin, internalFaultPin, brk} = 3'b001 << i;
			{outFaultMask, alarmFaultMask} = {fm[i], fm[i]};
			tk(1);
			chk({alarmActive, outLevel}, {1'b1, faultLevel});
			{outFaultMask, alarmFaultMask} = {~fm[i] & 5'h13, ~fm[i] & 5'h13};
			tk(1);
			chk({alarmActive, outFaultActive}, 2'b00);
		end
		{tempFaultPin, internalFaultPin, brk} = 3'b000;
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		chk({alarmActive, outLevel}, 17'h0);
		stop_test();
	end
endmodule
`default_nettype wire
